// ===== adcsr_pkg.sv
// Shared constants, types and helpers for the select-mode serial readout.
// Assumes a 125 MHz system clock; the readout and its bench import this package.
package adcsr_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CONV_TIME_NS  = 1000; // Internal conversion time
    localparam int CONV_CNT_W    = 16;

    // Least time, so round up to whole cycles, never below one
    function automatic int ns_to_cycles(input int ns);
        int cyc;
        cyc = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    // ------------------------------------------------------------------
    // Result and frame layout
    // ------------------------------------------------------------------
    localparam int RES_W      = 16;
    localparam int SREG_W     = RES_W + 1; // Start bit plus result
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] BITS_BUSY  = 5'h11;
    localparam logic [CNT_W-1:0] BITS_PLAIN = 5'h10;
    localparam logic [CNT_W-1:0] LAST_BUSY  = 5'h10;
    localparam logic [CNT_W-1:0] LAST_PLAIN = 5'h0f;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_WAIT, ST_SHIFT} adcsr_state_t;

    typedef struct packed {
        logic conversion_start;
        logic serial_data_in;
    } adcsr_pins_t;

    typedef struct packed {
        logic oe;
        logic dat;
    } adcsr_sdo_t;

    localparam adcsr_pins_t PINS_RST = 2'h3;
    localparam adcsr_sdo_t  SDO_HIZ  = 2'h0;
    localparam adcsr_sdo_t  SDO_LOW  = 2'h2;

    // Frame length depends on whether a start bit leads the data
    function automatic logic [CNT_W-1:0] bit_limit(input logic busy);
        return busy ? BITS_BUSY : BITS_PLAIN;
    endfunction

endpackage

// ===== adcsr_mem.sv
// Small two-port word store for the sample FIFO.
// Assumes one clock; read data are registered, one cycle after the address.
`timescale 1ns/1ps
module adcsr_mem #(
    parameter int W  = 16,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [D];

    // ------------------------------------------------------------------
    // Write port; contents need no reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

// ===== adcsr_fifo.sv
// Sample FIFO between the converter core and the serial readout.
// Assumes one clock; output valid hides the one-cycle memory read latency.
`timescale 1ns/1ps
module adcsr_fifo #(
    parameter int W  = 16,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   count_q;
    logic          lag_q;
    logic          push;
    logic          pop;

    // Handshakes; pop only when the registered word is current
    assign in_ready  = (count_q != (AW+1)'(D));
    assign out_valid = (count_q != '0) && !lag_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
            if (pop) rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
            count_q <= (AW+1)'(count_q + push - pop);
        end
    end

    // Stale read data for one cycle after a pop or a push into empty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lag_q <= 1'b0;
        end else begin
            lag_q <= pop || (push && count_q == '0);
        end
    end

    adcsr_mem #(.W(W), .D(D), .AW(AW)) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (push),
        .waddr (wr_ptr_q),
        .wdata (in_data),
        .raddr (rd_ptr_q),
        .rdata (out_data)
    );

endmodule

// ===== adcsr_readout.sv
// Conversion trigger and select-mode serial readout of a 16-bit converter.
// Assumes pins asynchronous to CLK; SERIAL_CLOCK is the host's link clock.
//
// Overview of operation
// - 3-wire, data-in high: start rise begins conversion, select mode, output tri-stated.
// - Busy-indicator 3-wire: output stays tri-stated until conversion ends, start ignored.
// - Busy indicator active: output goes from tri-state to low at conversion end.
// - After each conversion, core powers down until next start rise.
// - Result shifts out MSB first, one bit per serial clock fall.
// - 3-wire busy: output tri-states at 17th fall or start rise, first.
// - 4-wire, data-in high: start rise begins conversion, select mode, tri-state.
// - Data-in and start both low: output driven low; here it is tri-stated during conversion and carries result bits while shifting.
// - 4-wire no busy: MSB appears when data-in falls; rest on falls.
// - 4-wire no busy: tri-state at 16th fall or data-in rise, first.
// - 4-wire busy: tri-state at 17th fall or data-in rise, first.
// - Data-in level at start rise picks select mode (high) or chain (low).
// - Busy indicator enabled if start or data-in is low at conversion end.
`timescale 1ns/1ps
module adcsr_readout
    import adcsr_pkg::*;
#(
    parameter int CONV_NS = CONV_TIME_NS,
    parameter int DEPTH   = FIFO_DEPTH
) (
    input  wire logic             CLK,
    input  wire logic             NRST,
    input  wire logic             SERIAL_CLOCK,
    input  wire logic             CONVERSION_START,
    input  wire logic             SERIAL_DATA_IN,
    output logic                  SERIAL_DATA_OUT,
    output logic                  SERIAL_DATA_OUT_OE,
    input  wire logic [RES_W-1:0] SMP_DATA,
    input  wire logic             SMP_VALID,
    output logic                  SMP_READY,
    output logic                  CORE_POWER_ON,
    output logic                  CHAIN_MODE
);

    localparam int CONV_CYC = ns_to_cycles(CONV_NS);
    localparam logic [CONV_CNT_W-1:0] CONV_LOAD = CONV_CNT_W'(CONV_CYC - 1);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                  rst_s1_q;
    logic                  rst_n_q;
    logic                  sck_tog_q;
    logic                  sck_s1_q;
    logic                  sck_s2_q;
    logic                  sck_s3_q;
    adcsr_pins_t           pins_s1_q;
    adcsr_pins_t           pins_s2_q;
    adcsr_pins_t           pins_prev_q;
    adcsr_state_t          state_q;
    adcsr_state_t          state_d;
    logic [CONV_CNT_W-1:0] conv_cnt_q;
    logic [SREG_W-1:0]     sreg_q;
    logic [SREG_W-1:0]     sreg_d;
    logic [CNT_W-1:0]      bit_cnt_q;
    logic [CNT_W-1:0]      bit_cnt_d;
    logic [RES_W-1:0]      res_q;
    logic [RES_W-1:0]      res_d;
    logic                  busy_q;
    logic                  busy_d;
    logic                  chain_q;
    logic                  chain_d;
    adcsr_sdo_t            sdo_q;
    adcsr_sdo_t            sdo_d;
    logic                  core_q;
    logic                  tick;
    logic                  start_ev;
    logic                  both_low;
    logic                  deselect;
    logic                  busy_sel;
    logic                  conv_done;
    logic                  pop;
    logic [RES_W-1:0]      fifo_data;
    logic                  fifo_valid;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Asserts at once, releases two CLK edges later
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------------
    // One toggle per serial clock fall; the link clock may stop between
    // frames, so nothing else lives here and no edge is owed afterwards
    always_ff @(negedge SERIAL_CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sck_tog_q <= 1'b0;
        end else begin
            sck_tog_q <= ~sck_tog_q;
        end
    end

    // ------------------------------------------------------------------
    // Crossings into CLK
    // ------------------------------------------------------------------
    // Toggle synchroniser; third stage only feeds the edge detect
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
        end else begin
            sck_s1_q <= sck_tog_q;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    // Pin synchroniser; reset as idle-high so release makes no false start
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pins_s1_q   <= PINS_RST;
            pins_s2_q   <= PINS_RST;
            pins_prev_q <= PINS_RST;
        end else begin
            pins_s1_q   <= '{conversion_start: CONVERSION_START, serial_data_in: SERIAL_DATA_IN};
            pins_s2_q   <= pins_s1_q;
            pins_prev_q <= pins_s2_q;
        end
    end

    // Decoded events; a serial clock fall costs about three CLK cycles,
    // well inside half a link period, so data settle before the rise
    assign tick      = sck_s2_q ^ sck_s3_q;
    assign start_ev  = pins_s2_q.conversion_start && !pins_prev_q.conversion_start;
    assign both_low  = !pins_s2_q.conversion_start && !pins_s2_q.serial_data_in;
    assign deselect  = pins_s2_q.conversion_start && pins_s2_q.serial_data_in;
    assign busy_sel  = !pins_s2_q.conversion_start || !pins_s2_q.serial_data_in;
    assign conv_done = (state_q == ST_CONV) && (conv_cnt_q == '0);

    // ------------------------------------------------------------------
    // Conversion timer
    // ------------------------------------------------------------------
    // A new start during conversion is ignored until completion
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conv_cnt_q <= '0;
        end else if (start_ev && state_q != ST_CONV) begin
            conv_cnt_q <= CONV_LOAD;
        end else if (state_q == ST_CONV && conv_cnt_q != '0) begin
            conv_cnt_q <= CONV_CNT_W'(conv_cnt_q - 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Next state, frame shifter and mode flags
    always_comb begin
        state_d   = state_q;
        sreg_d    = sreg_q;
        bit_cnt_d = bit_cnt_q;
        res_d     = res_q;
        busy_d    = busy_q;
        chain_d   = chain_q;
        pop       = 1'b0;
        unique case (state_q)
            ST_CONV: begin
                if (conv_done) begin
                    // Empty FIFO: previous result is sent again
                    pop = fifo_valid;
                    if (fifo_valid) begin
                        res_d = fifo_data;
                    end
                    bit_cnt_d = '0;
                    if (chain_q) begin
                        busy_d  = 1'b0;
                        state_d = ST_ACQ;
                    end else if (busy_sel) begin
                        busy_d  = 1'b1;
                        state_d = ST_SHIFT;
                        sreg_d  = {1'b0, res_d};
                    end else begin
                        busy_d  = 1'b0;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (!deselect) begin
                    state_d   = ST_SHIFT;
                    sreg_d    = {res_q, 1'b0};
                    bit_cnt_d = '0;
                end
            end
            ST_SHIFT: begin
                if (deselect) begin
                    state_d = ST_ACQ;
                end else if (tick) begin
                    sreg_d    = {sreg_q[SREG_W-2:0], 1'b0};
                    bit_cnt_d = CNT_W'(bit_cnt_q + 1'b1);
                    if (bit_cnt_d == bit_limit(busy_q)) begin
                        state_d = ST_ACQ;
                    end
                end
            end
            ST_ACQ: begin
            end
        endcase
        // Start wins over any readout still in progress
        if (start_ev && state_q != ST_CONV) begin
            state_d = ST_CONV;
            chain_d = !pins_s2_q.serial_data_in;
        end
    end

    // Output pin value; tri-state has priority during conversion
    always_comb begin
        if (state_d == ST_SHIFT) begin
            sdo_d = '{oe: 1'b1, dat: sreg_d[SREG_W-1]};
        end else if (state_d != ST_CONV && both_low) begin
            sdo_d = SDO_LOW;
        end else begin
            sdo_d = SDO_HIZ;
        end
    end

    // State and shifter registers
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q   <= ST_ACQ;
            sreg_q    <= '0;
            bit_cnt_q <= '0;
        end else begin
            state_q   <= state_d;
            sreg_q    <= sreg_d;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // Result word and mode flags
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            res_q   <= '0;
            busy_q  <= 1'b0;
            chain_q <= 1'b0;
        end else begin
            res_q   <= res_d;
            busy_q  <= busy_d;
            chain_q <= chain_d;
        end
    end

    // Registered pins, aligned with state_q
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sdo_q  <= SDO_HIZ;
            core_q <= 1'b0;
        end else begin
            sdo_q  <= sdo_d;
            core_q <= (state_d == ST_CONV);
        end
    end

    // ------------------------------------------------------------------
    // Sample buffer
    // ------------------------------------------------------------------
    // Drained once per conversion, so a fast source really fills it
    adcsr_fifo #(.W(RES_W), .D(DEPTH)) u_fifo (
        .clk       (CLK),
        .rst_n     (rst_n_q),
        .in_data   (SMP_DATA),
        .in_valid  (SMP_VALID),
        .in_ready  (SMP_READY),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    assign SERIAL_DATA_OUT    = sdo_q.dat;
    assign SERIAL_DATA_OUT_OE = sdo_q.oe;
    assign CORE_POWER_ON      = core_q;
    assign CHAIN_MODE         = chain_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n_q);

    a_start_hiz: assert property (
        start_ev && pins_s2_q.serial_data_in && state_q != ST_CONV
        |=> state_q == ST_CONV && !sdo_q.oe && !chain_q)
        else $error("start did not tri-state in select mode");

    a_conv_hold_hiz: assert property (
        state_q == ST_CONV |-> !sdo_q.oe && core_q)
        else $error("output driven during conversion");

    a_conv_length: assert property (
        start_ev && state_q != ST_CONV |=> (state_q == ST_CONV)[*8])
        else $error("conversion ended too early");

    a_busy_low: assert property (
        conv_done && !chain_q && busy_sel |=> sdo_q == SDO_LOW && busy_q)
        else $error("busy start bit not driven low");

    a_power_down: assert property (
        conv_done |=> !core_q ##1 !core_q || $past(start_ev))
        else $error("core still powered after conversion");

    a_msb_shift: assert property (
        state_q == ST_SHIFT && tick && !deselect && !start_ev
        && CNT_W'(bit_cnt_q + 1'b1) != bit_limit(busy_q)
        |=> sdo_q.oe && sdo_q.dat == $past(sreg_q[SREG_W-2]))
        else $error("shift order wrong");

    a_busy_end: assert property (
        state_q == ST_SHIFT && busy_q && tick && bit_cnt_q == LAST_BUSY
        && !both_low |=> !sdo_q.oe)
        else $error("busy frame not ended at 17th fall");

    a_plain_end: assert property (
        state_q == ST_SHIFT && !busy_q && tick && bit_cnt_q == LAST_PLAIN
        && !both_low |=> !sdo_q.oe)
        else $error("plain frame not ended at 16th fall");

    a_deselect_hiz: assert property (
        state_q == ST_SHIFT && deselect |=> !sdo_q.oe)
        else $error("output kept after deselect");

    a_both_low: assert property (
        state_q == ST_ACQ && both_low |=> sdo_q == SDO_LOW)
        else $error("both-low did not drive output low");

    a_msb_select: assert property (
        state_q == ST_WAIT && !deselect && !start_ev
        |=> sdo_q.oe && sdo_q.dat == $past(res_q[RES_W-1]))
        else $error("MSB not presented on select");

    a_mode_pick: assert property (
        start_ev && state_q != ST_CONV |=> chain_q == !$past(pins_s2_q.serial_data_in))
        else $error("mode not taken from data-in at start");

    a_busy_pick: assert property (
        conv_done && !chain_q |=> busy_q == $past(busy_sel))
        else $error("busy indicator choice wrong");

    c_busy_frame: cover property (
        state_q == ST_SHIFT && busy_q && tick && bit_cnt_q == LAST_BUSY);
    c_plain_frame: cover property (
        state_q == ST_SHIFT && !busy_q && tick && bit_cnt_q == LAST_PLAIN);
    c_early_deselect: cover property (state_q == ST_SHIFT && deselect);
    c_chain_start: cover property (start_ev && !pins_s2_q.serial_data_in);

endmodule

// ===== adcsr_host.sv
// Host model: start line, data-in line and serial clock of the readout.
// Assumes the bench resolves the output wire with a pull-up.
`timescale 1ns/1ps
module adcsr_host (
    input  wire logic clk,
    output logic      conversion_start,
    output logic      serial_data_in,
    output logic      sck,
    input  wire logic serial_data_out
);
    // Idle: start low, data-in high, link clock parked high
    initial begin
        conversion_start = 1'h0;
        serial_data_in = 1'h1;
        sck = 1'h1;
    end

    // Pins move just after a system clock edge, then hold
    task automatic pins(input logic c, input logic s);
        @(posedge clk);
        conversion_start <= c;
        serial_data_in <= s;
    endtask

    // Sample before each fall; clock stands still between frames
    task automatic clock_in(input int n, output logic [16:0] v);
        v = 17'h0;
        for (int k = 0; k < n; k++) begin
            #62.5;
            v = {v[15:0], serial_data_out};
            sck = 1'h0;
            #62.5;
            sck = 1'h1;
        end
        #100;
    endtask
endmodule

// ===== test_adcsr_readout.sv
// Bench for the select-mode readout: fills the FIFO, then converts and reads.
// Assumes a short conversion parameter; output wire has a pull-up.
`timescale 1ns/1ps
module test_adcsr_readout;
    import adcsr_pkg::*;
    logic             clk, nrst, smp_valid, serial_data_out, oe, rdy, pwr, chn;
    logic [RES_W-1:0] smp_data, last_w, nw;
    logic [16:0]      v;
    logic [RES_W-1:0] exp_q[$];
    wire              conversion_start, serial_data_in, sck, sdo_w;
    int               miscompares, comparisons, cyc, m;
    int               seed = 32'he3b8a3be;

    assign sdo_w = oe ? serial_data_out : 1'h1; // Pull-up while released

    adcsr_readout #(.CONV_NS(80), .DEPTH(16)) i_adcsr_readout (
        .CLK(clk), .NRST(nrst), .SERIAL_CLOCK(sck), .CONVERSION_START(conversion_start),
        .SERIAL_DATA_IN(serial_data_in), .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OUT_OE(oe),
        .SMP_DATA(smp_data), .SMP_VALID(smp_valid), .SMP_READY(rdy),
        .CORE_POWER_ON(pwr), .CHAIN_MODE(chn));
    adcsr_host i_adcsr_host (.clk(clk), .conversion_start(conversion_start), .serial_data_in(serial_data_in), .sck(sck), .serial_data_out(sdo_w));

    // ------
    // Checking
    // ------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({16'h0, got}, {16'h0, exp});
    endtask
    task automatic report_and_stop();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Each conversion takes the oldest word; an empty FIFO repeats the last
    function automatic logic [RES_W-1:0] next_word();
        if (exp_q.size() > 0) last_w = exp_q.pop_front();
        return last_w;
    endfunction

    // Modes: 0 3-wire busy, 1 4-wire plain, 2 4-wire busy, 3 4-wire plain cut short
    task automatic run(input int md);
        logic [RES_W-1:0] w;
        logic             busy;
        busy = (md == 0) || (md == 2);
        w = next_word();
        i_adcsr_host.pins(1'h1, 1'h1);
        repeat (5) @(posedge clk);
        chk1(oe, 1'h0);
        chk1(pwr, 1'h1);
        if (md == 0) i_adcsr_host.pins(1'h0, 1'h1);
        if (md == 2) i_adcsr_host.pins(1'h1, 1'h0);
        chk1(oe, 1'h0);
        if (busy) begin
            for (int k = 0; k < 40 && sdo_w !== 1'h0; k++) @(posedge clk);
            chk({15'h0, oe, serial_data_out}, 17'h2);
        end else begin
            repeat (20) @(posedge clk);
            chk1(oe, 1'h0);
            i_adcsr_host.pins(1'h1, 1'h0);
            repeat (6) @(posedge clk);
        end
        chk1(pwr, 1'h0);
        chk1(chn, 1'h0);
        if (md == 3) begin
            i_adcsr_host.clock_in(8, v);
            chk(v, {9'h0, w[15:8]});
            i_adcsr_host.pins(1'h1, 1'h1);
            repeat (5) @(posedge clk);
        end else begin
            i_adcsr_host.clock_in(busy ? 17 : 16, v);
            chk(v, {1'h0, w});
        end
        chk1(oe, 1'h0);
        i_adcsr_host.pins(1'h0, 1'h1);
        repeat (4) @(posedge clk);
    endtask

    // Clock and hang limit
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // Main sequence: fill buffer, chain start, then mixed frames
    initial begin
        nrst = 1'h0;
        smp_valid = 1'h0;
        smp_data = 16'h0;
        last_w = 16'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 17; i++) begin
            @(posedge clk);
            // Draw once so the driven word and the expected word agree
            nw = (i == 0) ? 16'h8001 : (i == 1) ? 16'h7ffe : 16'($random(seed));
            smp_data <= nw;
            smp_valid <= 1'h1;
            if (i < 16) exp_q.push_back(nw);
        end
        repeat (3) @(posedge clk);
        chk1(rdy, 1'h0);
        smp_valid <= 1'h0;
        i_adcsr_host.pins(1'h0, 1'h0);
        repeat (6) @(posedge clk);
        chk({15'h0, oe, serial_data_out}, 17'h2);
        i_adcsr_host.pins(1'h1, 1'h0);
        repeat (5) @(posedge clk);
        chk1(chn, 1'h1);
        last_w = next_word();
        repeat (20) @(posedge clk);
        i_adcsr_host.pins(1'h0, 1'h1);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 17; i++) begin
            m = (i < 4) ? i : {$random(seed)} % 4;
            run(m);
        end
        chk1(rdy, 1'h1);
        report_and_stop();
    end
endmodule
